// >>> rtl/match_timer_core.sv
`timescale 1ns/10ps
module match_timer_core
  import match_timer_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register side
  timer_reg_if.core regs,
  input wire logic [7:0] period_limit,
  // Events
  output logic match_pulse,
  output logic post_event
);
  typedef struct packed {
    logic [7:0] count;
    logic [6:0] control;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic match;
    logic post;
  } core_state_t;

  core_state_t cur;
  core_state_t next_cur;
  logic tick;
  logic hit;

  // Next state of counter and scalers
  always_comb begin
    next_cur = cur;
    next_cur.match = 1'b0;
    next_cur.post = 1'b0;
    tick = cur.control[CTL_RUN_BIT] && (cur.pre_cnt == pre_tc(cur.control[1:0]));
    hit = tick && (cur.count == period_limit);
    if (cur.control[CTL_RUN_BIT]) begin
      next_cur.pre_cnt = tick ? 4'h0 : cur.pre_cnt + 4'h1;
    end
    if (tick) begin
      next_cur.count = hit ? 8'h00 : cur.count + 8'h01;
    end
    if (hit) begin
      next_cur.match = 1'b1;
      if (cur.post_cnt == cur.control[6:3]) begin
        next_cur.post_cnt = 4'h0;
        next_cur.post = 1'b1;
      end else begin
        next_cur.post_cnt = cur.post_cnt + 4'h1;
      end
    end
    // Software writes win over counting and clear both scalers
    if (regs.wr_count) begin
      next_cur.count = regs.wdata;
      next_cur.pre_cnt = 4'h0;
      next_cur.post_cnt = 4'h0;
    end
    if (regs.wr_control) begin
      next_cur.control = regs.wdata[6:0];
      next_cur.pre_cnt = 4'h0;
      next_cur.post_cnt = 4'h0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '{count: RST_TICK_COUNT, control: RST_CONTROL, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign regs.count = cur.count;
  assign regs.control = cur.control;
  assign match_pulse = cur.match;
  assign post_event = cur.post;
endmodule

// >>> rtl/match_timer_pkg.sv
package match_timer_pkg;
  // Register byte offsets on the bus
  localparam logic [3:0] OFS_TICK_COUNT = 4'h0;
  localparam logic [3:0] OFS_PERIOD_LIMIT = 4'h4;
  localparam logic [3:0] OFS_TIMER_CONTROL = 4'h8;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'hC;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h0;
  localparam logic [4:0] OFS_IRQ_ENABLE_FULL = 5'h10;
  // Control field positions
  localparam int CTL_POST_LSB = 3;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_PRE_LSB = 0;
  // Reset values
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
  localparam logic [7:0] RST_TICK_COUNT = 8'h00;
  localparam logic [6:0] RST_CONTROL = 7'h00;
  // Prescale terminal counts (divide minus one)
  localparam logic [3:0] PRE_TC_DIV1 = 4'h0;
  localparam logic [3:0] PRE_TC_DIV4 = 4'h3;
  localparam logic [3:0] PRE_TC_DIV16 = 4'hF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Prescaler terminal count from select code
  function automatic logic [3:0] pre_tc(input logic [1:0] sel);
    if (sel[1]) begin
      return PRE_TC_DIV16;
    end else if (sel[0]) begin
      return PRE_TC_DIV4;
    end
    return PRE_TC_DIV1;
  endfunction
endpackage

// >>> rtl/period_match_timer.sv
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
// How it works
// - Prescaler divides instruction clock by 1, 4 or 16 per two-bit select.
// - Counter counts up from zero, returns to zero after equalling period.
// - Period register is read/write and resets to all ones.
// - Counter register is read/write and clears on every reset.
// - Matches feed a postscaler; select value plus one matches per event.
// - Postscaler event sets a latched interrupt flag until software clears it.
// - Writes to counter or control, and reset, clear both scaler counts.
// - Control writes leave the counter value unchanged.
// - Run enable bit starts counting when one, stops it when zero.
// - Control bits 6:3 postscale, bit 2 run, bits 1:0 prescale, reset zero.
// - Unscaled match goes only to the PWM units as a time base.
module period_match_timer
  import match_timer_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [4:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [4:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Time base to PWM units and interrupt
  output logic pwm_time_base,
  output logic irq
);

  // Bus timing as the master sees it:
  // address and data are taken each at its own valid and ready edge,
  // in either order, and held here until both are in;
  // the write executes one edge after the later of the two,
  // and bvalid rises at that edge with the register already changed;
  // read data is captured at the address edge and shown from the next edge;
  // each response stands until its ready is seen high.
  // Only byte lane 0 carries register bits; upper lanes read zero.
  // A write to a mapped register with lane 0 off answers OKAY and changes nothing.
  // Unmapped addresses answer SLVERR, read zero and change nothing.

  // Register picked by a word address
  // One-hot, and each write strobe compares the whole six-bit code,
  // and a wrong decode never hits two registers at once
  typedef enum logic [5:0] {
    SEL_NONE = 6'b000001,
    SEL_COUNT = 6'b000010,
    SEL_PERIOD = 6'b000100,
    SEL_CONTROL = 6'b001000,
    SEL_STATUS = 6'b010000,
    SEL_ENABLE = 6'b100000
  } reg_sel_t;

  // Everything kept between edges
  typedef struct packed {
    // Write address and data, latched apart
    logic aw_held;
    logic [4:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    // Write response
    logic bvalid;
    logic [1:0] bresp;
    // Read response
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Registers kept beside the core
    logic [7:0] period_limit;
    logic match_irq_flag;
    logic match_irq_enable;
  } top_state_t;

  top_state_t cur;
  top_state_t next_cur;
  timer_reg_if regs();
  // Core events
  logic match_pulse;
  logic post_event;
  // Handshakes completing at this edge
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic b_done;
  logic r_done;
  // Write side
  logic do_write;
  logic wr_ok;
  reg_sel_t wsel;
  logic wr_period;
  logic wr_enable;
  logic wr_clear;
  // Read side
  logic [4:0] ra;
  reg_sel_t rsel;
  logic [31:0] rword;

  // Timer core holds counter, control and scalers
  // It sees writes as one-cycle strobes with the low data byte
  match_timer_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .regs(regs),
    .period_limit(cur.period_limit),
    .match_pulse(match_pulse),
    .post_event(post_event)
  );

  // Address decode shared by both bus sides
  // Callers pass word-aligned addresses; the guard below
  // keeps a stray unaligned one from hitting a register
  function automatic reg_sel_t decode_sel(input logic [4:0] a);
    reg_sel_t sel;
    sel = SEL_NONE;

    case (a)
      {1'b0, OFS_TICK_COUNT}: begin
        sel = SEL_COUNT;
      end
      {1'b0, OFS_PERIOD_LIMIT}: begin
        sel = SEL_PERIOD;
      end
      {1'b0, OFS_TIMER_CONTROL}: begin
        sel = SEL_CONTROL;
      end
      {1'b0, OFS_IRQ_STATUS}: begin
        sel = SEL_STATUS;
      end
      OFS_IRQ_ENABLE_FULL: begin
        sel = SEL_ENABLE;
      end
      default: begin
        sel = SEL_NONE;
      end
    endcase

    // Unaligned addresses map to nothing
    if (a[1:0] != 2'h0) begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction

  // A register is mapped when the decode finds it
  function automatic logic mapped(input reg_sel_t sel);
    return sel != SEL_NONE;
  endfunction

  // Read value of the selected register
  // Unused bits read zero, so software need mask nothing
  function automatic logic [31:0] read_word(
    input reg_sel_t sel,
    input logic [7:0] cnt,
    input logic [6:0] ctl,
    input logic [7:0] per,
    input logic flag,
    input logic en
  );
    logic [31:0] w;
    w = 32'h00000000;

    case (sel)
      SEL_COUNT: begin
        w[7:0] = cnt;
      end
      SEL_PERIOD: begin
        w[7:0] = per;
      end
      SEL_CONTROL: begin
        w[6:0] = ctl;
      end
      SEL_STATUS: begin
        w[0] = flag;
      end
      SEL_ENABLE: begin
        w[0] = en;
      end
      default: begin
        w = 32'h00000000;
      end
    endcase

    return w;
  endfunction

  // Channel readies
  // A pending response holds off the next write, so
  // at most one write is ever inside the block
  assign s_axi_awready = !cur.aw_held && !cur.bvalid;
  assign s_axi_wready = !cur.w_held && !cur.bvalid;
  assign s_axi_arready = !cur.rvalid;

  // Handshakes completing at this edge
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign b_done = cur.bvalid && s_axi_bready;
  assign r_done = cur.rvalid && s_axi_rready;

  // Write executes once both halves are in
  assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;
  // Only byte lane 0 carries register bits
  assign wr_ok = do_write && cur.wstrb[0];
  // Target register of the held address
  assign wsel = decode_sel(cur.awaddr);

  // Core write strobes
  // Counter and control live in the core, which also clears its scalers
  assign regs.wdata = cur.wdata[7:0];
  assign regs.wr_count = wr_ok && (wsel == SEL_COUNT);
  assign regs.wr_control = wr_ok && (wsel == SEL_CONTROL);

  // Strobes for registers kept here
  assign wr_period = wr_ok && (wsel == SEL_PERIOD);
  assign wr_enable = wr_ok && (wsel == SEL_ENABLE);
  assign wr_clear = wr_ok && (wsel == SEL_STATUS) && cur.wdata[0];

  // Read address taken word aligned; value sampled at the handshake edge
  assign ra = {s_axi_araddr[4:2], 2'h0};
  assign rsel = decode_sel(ra);
  assign rword = read_word(rsel, regs.count, regs.control, cur.period_limit, cur.match_irq_flag,
                           cur.match_irq_enable);

  // Priorities inside one cycle:
  // a write executes before the flag logic looks at it,
  // an event setting the flag beats a clear written in the same cycle,
  // and a read taken at an edge can not also retire at it.
  always_comb begin
    next_cur = cur;

    // Write address channel
    if (aw_take) begin
      next_cur.aw_held = 1'b1;
      next_cur.awaddr = {s_axi_awaddr[4:2], 2'h0};
    end

    // Write data channel
    if (w_take) begin
      next_cur.w_held = 1'b1;
      next_cur.wdata = s_axi_wdata;
      next_cur.wstrb = s_axi_wstrb;
    end

    // Both halves in: execute and raise the response
    if (do_write) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      if (mapped(wsel)) begin
        next_cur.bresp = RESP_OKAY;
      end else begin
        next_cur.bresp = RESP_SLVERR;
      end
    end

    // Period register lives beside the core
    if (wr_period) begin
      next_cur.period_limit = cur.wdata[7:0];
    end

    // Interrupt enable bit
    if (wr_enable) begin
      next_cur.match_irq_enable = cur.wdata[0];
    end

    // Writing a one clears the flag
    if (wr_clear) begin
      next_cur.match_irq_flag = 1'b0;
    end

    // Set wins over a clear in the same cycle, so no event is lost
    if (post_event) begin
      next_cur.match_irq_flag = 1'b1;
    end

    // Write response retires at the bready edge
    if (b_done) begin
      next_cur.bvalid = 1'b0;
    end

    // Read address taken: capture data and response
    if (ar_take) begin
      next_cur.rvalid = 1'b1;
      next_cur.rdata = rword;
      if (mapped(rsel)) begin
        next_cur.rresp = RESP_OKAY;
      end else begin
        next_cur.rresp = RESP_SLVERR;
      end
    end else if (r_done) begin
      next_cur.rvalid = 1'b0;
    end
  end

  // State register
  // Synchronous reset; every field starts from a constant
  // The core resets its own counter, control and scalers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '{period_limit: RST_PERIOD_LIMIT, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // Bus responses straight from flops
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;

  // Unscaled match goes to the PWM units only
  assign pwm_time_base = match_pulse;

  // Interrupt is the AND of two flops
  // so it never glitches and adds no delay
  // Masking does not touch the flag; software may still poll it
  assign irq = cur.match_irq_flag && cur.match_irq_enable;
endmodule

// >>> rtl/timer_reg_if.sv
`timescale 1ns/10ps
// Register-side view shared by the bus slave and the timer core
interface timer_reg_if;
  logic wr_count;
  logic wr_control;
  logic [7:0] wdata;
  logic [7:0] count;
  logic [6:0] control;
  modport slave(output wr_count, output wr_control, output wdata, input count, input control);
  modport core(input wr_count, input wr_control, input wdata, output count, output control);
endinterface

// >>> sim/match_timer_props.sv
`timescale 1ns/10ps
module match_timer_props (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Bus handshakes
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [1:0] s_axi_bresp,
  input logic [31:0] s_axi_rdata,
  // Timer outputs
  input logic pwm_time_base,
  input logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_wr_done; !s_axi_bvalid ##1 s_axi_bvalid; endsequence
  property p_wr_ans; s_wr_take |=> s_wr_done; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("late write response");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("late read data");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_no_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_no_ar: assert property (p_no_ar) else $error("read taken while busy");
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  // Interrupt moves only on a match or a register write
  property p_irq_set; $rose(irq) |-> $past(pwm_time_base) || $rose(s_axi_bvalid); endproperty
  a_irq_set: assert property (p_irq_set) else $error("stray interrupt");
  property p_irq_clr; $fell(irq) |-> $rose(s_axi_bvalid); endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt lost");
endmodule

// >>> sim/pwm_sink.sv
`timescale 1ns/10ps
module pwm_sink (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Time base in, match tally out
  input logic time_base,
  output int unsigned n_base
);
  // A PWM unit restarts its ramp on each match cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) n_base <= 0;
    else if (time_base) n_base <= n_base + 1;
  end
endmodule

// >>> sim/test_period_match_timer.sv
`timescale 1ns/10ps
module test_period_match_timer;
  import match_timer_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_time_base, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int unsigned n_base;
  int failures = 0, n_compared = 0, cycles = 0;
  localparam logic [4:0] A_CNT = {1'b0, OFS_TICK_COUNT}, A_PER = {1'b0, OFS_PERIOD_LIMIT};
  localparam logic [4:0] A_CTL = {1'b0, OFS_TIMER_CONTROL}, A_STS = {1'b0, OFS_IRQ_STATUS};
  localparam logic [4:0] A_ENA = OFS_IRQ_ENABLE_FULL;

  period_match_timer u_period_match_timer (.*);
  pwm_sink u_pwm_sink (.aclk(aclk), .aresetn(aresetn), .time_base(pwm_time_base), .n_base(n_base));

  initial forever #4 aclk = ~aclk;
  // Watchdog; the full run needs under a thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Each channel released at its own handshake edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        check("bresp", s_axi_bresp, er);
        s_axi_bready <= 0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        check("rdata", s_axi_rdata, exp);
        check("rresp", s_axi_rresp, er);
        s_axi_rready <= 0;
        break;
      end
    end
  endtask

  task automatic t_reset();
    rd(A_CNT, 32'h0);
    rd(A_PER, {24'h0, RST_PERIOD_LIMIT});
    rd(A_CTL, 32'h0);
    rd(A_STS, 32'h0);
    rd(A_ENA, 32'h0);
    rd(5'h14, 32'h0, RESP_SLVERR);
    wr(5'h14, 8'h01, RESP_SLVERR);
  endtask

  task automatic t_regs();
    wr(A_PER, 8'h5A);
    rd(A_PER, 32'h5A);
    wr(A_CTL, 8'hFB);
    rd(A_CTL, 32'h7B);
    wr(A_CNT, 8'h42);
    rd(A_CNT, 32'h42);
    wr(A_CTL, 8'h00);
    rd(A_CNT, 32'h42);
  endtask

  // Window of four periods holds exactly four matches at any phase
  task automatic t_prescale();
    int unsigned n0;
    int div;
    wr(A_CNT, 8'h00);
    wr(A_PER, 8'h03);
    for (int c = 0; c < 4; c++) begin
      div = c[1] ? 16 : (c[0] ? 4 : 1);
      wr(A_CTL, 8'h04 | 8'(c));
      repeat (2) @(posedge aclk);
      n0 = n_base;
      repeat (16 * div) @(posedge aclk);
      check("matches", n_base - n0, 32'h4);
    end
  endtask

  task automatic t_post();
    int unsigned n0;
    int sel[3] = '{0, 1, 15};
    wr(A_PER, 8'h01);
    wr(A_ENA, 8'h01);
    foreach (sel[k]) begin
      wr(A_CTL, 8'(sel[k] << 3));
      wr(A_CNT, 8'h00);
      wr(A_STS, 8'h01);
      check("irq", irq, 32'h0);
      n0 = n_base;
      wr(A_CTL, 8'(sel[k] << 3) | 8'h04);
      for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge aclk);
      check("matches per flag", n_base - n0, 32'(sel[k] + 1));
    end
    wr(A_CTL, 8'h00);
    rd(A_STS, 32'h1);
    wr(A_ENA, 8'h00);
    check("irq", irq, 32'h0);
    wr(A_ENA, 8'h01);
    check("irq", irq, 32'h1);
    wr(A_STS, 8'h01);
    rd(A_STS, 32'h0);
    check("irq", irq, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_regs();
    t_prescale();
    t_post();
    // Mid-run reset restores the defaults
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(A_PER, 32'hFF);
    rd(A_CNT, 32'h0);
    rd(A_CTL, 32'h0);
    rd(A_ENA, 32'h0);
    check("irq", irq, 32'h0);
    check("time base", pwm_time_base, 32'h0);
    wrap_up();
  end
endmodule

bind period_match_timer match_timer_props u_match_timer_props (.*);
